// ---- logic/tbrw_pkg.sv ----
// Purpose: shared constants of the Type B request / wake-up responder
// Assumes: byte-wide receive and transmit frame ports from the RF modem
// Notes:   offsets are byte addresses on the plain register port
package tbrw_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0] ADDR_CFG = 8'h00;   // afi, fwi, speed bits
    localparam logic [7:0] ADDR_PUPI = 8'h04;  // card identifier
    localparam logic [7:0] ADDR_STATE = 8'h08; // tag state
    localparam logic [7:0] ADDR_STAT = 8'h0C;  // event counters

    // config field positions
    localparam int CFG_AFI_LSB = 0;
    localparam int CFG_FWI_LSB = 8;
    localparam int CFG_RF_LIMIT_BIT = 12;
    localparam int CFG_TBSPD_BIT = 13;

    // reset values
    localparam logic [7:0] AFI_RESET = 8'h00;
    localparam logic [3:0] FWI_RESET = 4'h0;
    localparam logic [31:0] PUPI_RESET = 32'h0000_0000;

    // ************************************************************
    // command and answer coding
    // ************************************************************
    localparam logic [7:0] CMD_REQ_WAKE = 8'h05;
    localparam int PARAM_WAKE_BIT = 3;
    localparam logic [2:0] CMD_LEN = 3'h5;
    localparam logic [7:0] ANS_CODE = 8'h50;
    localparam logic [7:0] PROTO1_FAST = 8'hB3;
    localparam logic [7:0] PROTO1_SLOW = 8'h80;
    localparam logic [3:0] MAX_FRAME_CODE = 4'h8;  // 256 bytes
    localparam logic [3:0] PROTO_TYPE = 4'h1;      // block protocol
    localparam logic [3:0] PROTO3_LOW = 4'h0;      // adc and option
    localparam logic [3:0] ANS_LAST_DATA = 4'hB;   // index of byte 11
    localparam logic [3:0] ANS_LAST = 4'hD;        // index of byte 13
    localparam logic [3:0] ANS_CRC_LO = 4'hC;

    // ************************************************************
    // crc of the Type B link
    // ************************************************************
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'h8408;
    localparam logic [15:0] CRC_RESIDUE = 16'hF0B8;

    // tag state coding
    typedef enum logic [1:0] {
        TBRW_IDLE = 2'b00,
        TBRW_READY = 2'b01,
        TBRW_HALT = 2'b10
    } tbrw_state_t;

endpackage : tbrw_pkg

// ---- logic/tbrw_crc_if.sv ----
// Purpose: carrier between the responder and its crc engines
// Assumes: one clock, engine updates on the edge after en
// Notes:   clr wins over en
interface tbrw_crc_if;
    logic clr;          // reload the start value
    logic en;           // fold data in
    logic [7:0] data;   // byte to fold
    logic [15:0] crc;   // running remainder, not complemented

    modport eng (input clr, input en, input data, output crc);
    modport user (output clr, output en, output data, input crc);
endinterface : tbrw_crc_if

// ---- logic/tbrw_crc.sv ----
// Purpose: bytewise crc engine of the Type B link
// Assumes: data lsb first on the air, reflected polynomial
// Notes:   result is complemented by the user before sending
module tbrw_crc
    import tbrw_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // engine side of the carrier
    tbrw_crc_if.eng port
);

    // ************************************************************
    // one byte step, eight shifts unrolled by the loop
    // ************************************************************
    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction : crc_step

    logic [15:0] crc_reg; // running remainder

    // reload has priority so a new frame never inherits old state
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            crc_reg <= CRC_INIT;
        end else if (port.clr) begin
            crc_reg <= CRC_INIT;
        end else if (port.en) begin
            crc_reg <= crc_step(crc_reg, port.data);
        end
    end

    assign port.crc = crc_reg;

endmodule : tbrw_crc

// ---- logic/tbrw_responder.sv ----
// Purpose: tag-side handler of the Type B request and wake-up command
// Assumes: rx and tx byte ports come from modem logic on clk_sys
// Notes:   attribute command and higher layers live elsewhere
//
// The strobed register port and the address map were chosen for this implementation.
module tbrw_responder
    import tbrw_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // receive frame from the modem
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_last,
    // transmit frame to the modem
    output logic tx_valid,
    output logic [7:0] tx_data,
    output logic tx_last,
    input wire logic tx_ready,
    // tag state for neighbouring blocks
    output logic [1:0] tag_state
);

    // ************************************************************
    // configuration and state registers
    // ************************************************************
    logic [7:0] stored_afi_reg;          // stored family identifier
    logic [3:0] fwi_reg;                 // frame waiting time integer
    logic rf_speed_limit_bit_reg;        // 1 limits to 106 kbit/s
    logic type_b_speed_select_bit_reg;   // 1 enables faster rates
    logic [31:0] pupi_reg;               // identifier sent in answer
    tbrw_state_t state_reg;              // idle, ready or halted
    logic [7:0] ans_cnt_reg;             // answers sent
    logic [7:0] crc_err_cnt_reg;         // frames with bad crc
    logic [7:0] ign_cnt_reg;             // good frames left silent

    // ************************************************************
    // receive side bookkeeping
    // ************************************************************
    logic [2:0] rx_cnt_reg;              // bytes of current frame
    logic rx_ovf_reg;                    // frame longer than a command
    logic [7:0] cmd_reg;                 // command byte
    logic [7:0] afi_cmd_reg;             // requested family identifier
    logic [7:0] param_reg;               // parameter byte
    logic eval_reg;                      // frame ended last cycle

    // ************************************************************
    // transmit side bookkeeping
    // ************************************************************
    logic tx_busy_reg;                   // answer in flight
    logic tx_gap_reg;                    // one idle cycle before crc
    logic [3:0] tx_idx_reg;              // index of byte on tx_data
    logic tx_start;                      // launch an answer

    // crc carriers
    tbrw_crc_if rx_crc ();
    tbrw_crc_if tx_crc ();

    // ************************************************************
    // crc engines, one per direction
    // ************************************************************
    tbrw_crc u_rx_crc (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .port(rx_crc.eng)
    );

    tbrw_crc u_tx_crc (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .port(tx_crc.eng)
    );

    // ************************************************************
    // decode helpers
    // ************************************************************

    // family identifier filter against the stored value
    function automatic logic afi_match(input logic [7:0] req,
                                       input logic [7:0] mine);
        logic ok;
        if (req == 8'h00) begin
            ok = 1'b1;
        end else if (req[3:0] == 4'h0) begin
            ok = (req[7:4] == mine[7:4]);
        end else if (req[7:4] == 4'h0) begin
            ok = (req[3:0] == mine[3:0]);
        end else begin
            ok = (req == mine);
        end
        return ok;
    endfunction : afi_match

    // first protocol byte from the two speed bits
    function automatic logic [7:0] rate_byte(input logic limit,
                                             input logic fast);
        logic [7:0] b;
        if (limit) begin
            b = PROTO1_SLOW;
        end else if (fast) begin
            b = PROTO1_FAST;
        end else begin
            b = PROTO1_SLOW;
        end
        return b;
    endfunction : rate_byte

    // answer payload byte by index, crc bytes handled apart
    function automatic logic [7:0] ans_byte(input logic [3:0] idx,
                                            input logic [31:0] id,
                                            input logic [7:0] rate,
                                            input logic [3:0] fwi);
        logic [7:0] b;
        case (idx)
            4'h0: b = ANS_CODE;
            4'h1: b = id[31:24];
            4'h2: b = id[23:16];
            4'h3: b = id[15:8];
            4'h4: b = id[7:0];
            4'h9: b = rate;
            4'hA: b = {MAX_FRAME_CODE, PROTO_TYPE};
            4'hB: b = {fwi, PROTO3_LOW};
            default: b = 8'h00;
        endcase
        return b;
    endfunction : ans_byte

    // ************************************************************
    // frame decision
    // ************************************************************
    logic wake;        // wake-up variant
    logic crc_ok;      // residue check of the whole frame
    logic frame_ok;    // well formed command for this handler
    logic state_ok;    // variant allowed in current state
    logic answer;      // all conditions met

    // only bit 3 of the parameter matters; 7-5 and slots are dropped
    assign wake = param_reg[PARAM_WAKE_BIT];
    assign crc_ok = (rx_crc.crc == CRC_RESIDUE);
    assign frame_ok = !rx_ovf_reg && (rx_cnt_reg == CMD_LEN) &&
                      (cmd_reg == CMD_REQ_WAKE);
    // plain request is dropped while halted
    assign state_ok = wake || (state_reg != TBRW_HALT);
    assign answer = eval_reg && frame_ok && crc_ok && state_ok &&
                    afi_match(afi_cmd_reg, stored_afi_reg) &&
                    !tx_busy_reg;
    // answer starts at once; slot code never delays it
    assign tx_start = answer;

    // ************************************************************
    // crc carrier drive
    // ************************************************************
    assign rx_crc.clr = eval_reg;
    assign rx_crc.en = rx_valid && !eval_reg;
    assign rx_crc.data = rx_data;

    // tx crc covers the twelve payload bytes only
    assign tx_crc.clr = tx_start;
    assign tx_crc.en = tx_valid && tx_ready &&
                       (tx_idx_reg <= ANS_LAST_DATA);
    assign tx_crc.data = tx_data;

    // ************************************************************
    // receive byte capture
    // ************************************************************
    // the counter saturates so long frames are simply refused
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_cnt_reg <= 3'h0;
            rx_ovf_reg <= 1'b0;
            cmd_reg <= 8'h00;
            afi_cmd_reg <= 8'h00;
            param_reg <= 8'h00;
        end else if (eval_reg) begin
            // decision taken, ready for the next frame
            rx_cnt_reg <= 3'h0;
            rx_ovf_reg <= 1'b0;
        end else if (rx_valid) begin
            case (rx_cnt_reg)
                3'h0: cmd_reg <= rx_data;
                3'h1: afi_cmd_reg <= rx_data;
                3'h2: param_reg <= rx_data;
                default: ;
            endcase
            if (rx_cnt_reg == CMD_LEN) begin
                rx_ovf_reg <= 1'b1;
            end else begin
                rx_cnt_reg <= rx_cnt_reg + 3'h1;
            end
        end
    end

    // decide one cycle after the last byte, once crc has settled
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            eval_reg <= 1'b0;
        end else begin
            eval_reg <= rx_valid && rx_last && !eval_reg;
        end
    end

    // ************************************************************
    // answer transmitter
    // ************************************************************
    // a bubble before the crc lets the remainder take byte 11 first
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_busy_reg <= 1'b0;
            tx_gap_reg <= 1'b0;
            tx_idx_reg <= 4'h0;
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
            tx_last <= 1'b0;
        end else if (tx_start) begin
            tx_busy_reg <= 1'b1;
            tx_idx_reg <= 4'h0;
            tx_valid <= 1'b1;
            tx_data <= ANS_CODE;
            tx_last <= 1'b0;
        end else if (tx_gap_reg) begin
            // remainder now final: send its complement, low byte first
            tx_gap_reg <= 1'b0;
            tx_valid <= 1'b1;
            tx_data <= ~tx_crc.crc[7:0];
        end else if (tx_valid && tx_ready) begin
            if (tx_idx_reg == ANS_LAST) begin
                tx_busy_reg <= 1'b0;
                tx_valid <= 1'b0;
                tx_last <= 1'b0;
            end else if (tx_idx_reg == ANS_LAST_DATA) begin
                tx_idx_reg <= ANS_CRC_LO;
                tx_valid <= 1'b0;
                tx_gap_reg <= 1'b1;
            end else if (tx_idx_reg == ANS_CRC_LO) begin
                tx_idx_reg <= ANS_LAST;
                tx_data <= ~tx_crc.crc[15:8];
                tx_last <= 1'b1;
            end else begin
                tx_idx_reg <= tx_idx_reg + 4'h1;
                tx_data <= ans_byte(tx_idx_reg + 4'h1, pupi_reg,
                                    rate_byte(rf_speed_limit_bit_reg,
                                        type_b_speed_select_bit_reg),
                                    fwi_reg);
            end
        end
    end

    // ************************************************************
    // tag state
    // ************************************************************
    // answering declares the tag; software may move it elsewhere
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= TBRW_IDLE;
        end else if (answer) begin
            // wake-up is taken from halt as well as idle
            state_reg <= TBRW_READY;
        end else if (reg_wr && reg_addr == ADDR_STATE) begin
            case (reg_wdata[1:0])
                2'b00: state_reg <= TBRW_IDLE;
                2'b01: state_reg <= TBRW_READY;
                2'b10: state_reg <= TBRW_HALT;
                default: state_reg <= state_reg;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tag_state <= TBRW_IDLE;
        end else begin
            tag_state <= state_reg;
        end
    end

    // ************************************************************
    // configuration writes
    // ************************************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stored_afi_reg <= AFI_RESET;
            fwi_reg <= FWI_RESET;
            rf_speed_limit_bit_reg <= 1'b0;
            type_b_speed_select_bit_reg <= 1'b0;
            pupi_reg <= PUPI_RESET;
        end else if (reg_wr) begin
            if (reg_addr == ADDR_CFG) begin
                stored_afi_reg <= reg_wdata[CFG_AFI_LSB +: 8];
                fwi_reg <= reg_wdata[CFG_FWI_LSB +: 4];
                rf_speed_limit_bit_reg <= reg_wdata[CFG_RF_LIMIT_BIT];
                type_b_speed_select_bit_reg <= reg_wdata[CFG_TBSPD_BIT];
            end else if (reg_addr == ADDR_PUPI) begin
                pupi_reg <= reg_wdata;
            end
        end
    end

    // ************************************************************
    // event counters, wrap silently; a write to ADDR_STAT clears all three
    // ************************************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ans_cnt_reg <= 8'h00;
            crc_err_cnt_reg <= 8'h00;
            ign_cnt_reg <= 8'h00;
        end else if (reg_wr && reg_addr == ADDR_STAT) begin
            ans_cnt_reg <= 8'h00;
            crc_err_cnt_reg <= 8'h00;
            ign_cnt_reg <= 8'h00;
        end else if (eval_reg) begin
            if (answer) begin
                ans_cnt_reg <= ans_cnt_reg + 8'h01;
            end else if (!crc_ok) begin
                crc_err_cnt_reg <= crc_err_cnt_reg + 8'h01;
            end else begin
                ign_cnt_reg <= ign_cnt_reg + 8'h01;
            end
        end
    end

    // ************************************************************
    // register read, data stands one cycle after the strobe
    // ************************************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                ADDR_CFG: reg_rdata <= {18'h00000,
                    type_b_speed_select_bit_reg, rf_speed_limit_bit_reg,
                    fwi_reg, stored_afi_reg};
                ADDR_PUPI: reg_rdata <= pupi_reg;
                ADDR_STATE: reg_rdata <= {29'h00000000, tx_busy_reg,
                                          state_reg};
                ADDR_STAT: reg_rdata <= {8'h00, ign_cnt_reg,
                                         crc_err_cnt_reg, ans_cnt_reg};
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

endmodule : tbrw_responder

// ---- tb/tbrw_responder_monitor.sv ----
// Purpose: port checker of the Type B responder answer frame
// Assumes: answer bytes are counted as the modem takes them
// Notes: bound to every responder instance
module tbrw_responder_monitor
    import tbrw_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // transmit side
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    input wire logic tx_ready
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] idx; // index of the byte on offer
    // byte counter, back to zero after the final crc byte
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            idx <= 4'h0;
        end else if (tx_valid && tx_ready) begin
            idx <= tx_last ? 4'h0 : idx + 4'h1;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    code_first_a: assert property (
        tx_valid && idx == 4'h0 |-> tx_data == ANS_CODE)
        else $error("answer code wrong");
    app_zero_a: assert property (
        tx_valid && idx inside {[5:8]} |-> tx_data == 8'h00)
        else $error("application byte not zero");
    rate_byte_a: assert property (
        tx_valid && idx == 4'h9 |-> tx_data inside {8'hB3, 8'h80})
        else $error("rate byte wrong");
    size_type_a: assert property (
        tx_valid && idx == 4'hA |-> tx_data == 8'h81)
        else $error("second protocol byte wrong");
    wait_low_a: assert property (
        tx_valid && idx == 4'hB |-> tx_data[3:0] == 4'h0)
        else $error("third protocol byte low nibble set");
    last_byte_a: assert property (
        tx_valid && tx_last |-> idx == 4'hD)
        else $error("last flag on wrong byte");
    hold_byte_a: assert property (
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("byte dropped before taken");
    frame_end_a: assert property (
        tx_valid && tx_ready && tx_last |=> !tx_valid && !tx_last)
        else $error("frame did not end");
endmodule : tbrw_responder_monitor

bind tbrw_responder tbrw_responder_monitor tbrw_responder_monitor_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready));

// ---- tb/tbrw_reader.sv ----
// Purpose: reader side model sending request frames
// Assumes: one byte per cycle on the receive port
// Notes: stall makes the modem take a byte only every other cycle
module tbrw_reader
    import tbrw_pkg::*;
(
    input wire logic clk_sys,
    input wire logic stall,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_last,
    output logic tx_ready,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] ans [0:15]; // answer bytes as taken
    int n; // count of answer bytes
    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                              input logic [7:0] b);
        c = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++)
            c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
        return c;
    endfunction : crc_step
    // one request frame; bad flips a crc bit on purpose
    task automatic send(input logic [7:0] cmd, afi, param, input bit bad);
        logic [7:0] f [0:4];
        logic [15:0] c;
        c = crc_step(crc_step(crc_step(CRC_INIT, cmd), afi), param);
        c = ~c ^ {15'h0, bad};
        f = '{cmd, afi, param, c[7:0], c[15:8]};
        n = 0;
        for (int i = 0; i < 5; i++) begin
            @(posedge clk_sys);
            rx_valid <= 1'b1;
            rx_data <= f[i];
            rx_last <= (i == 4);
        end
        @(posedge clk_sys);
        rx_valid <= 1'b0;
        rx_last <= 1'b0;
        rx_data <= ~f[4]; // released bus shows no stale byte
    endtask : send
    // collect the answer; ready toggles while stalling
    always @(posedge clk_sys) begin
        if (tx_valid && tx_ready) begin
            ans[n[3:0]] = tx_data;
            n = n + 1;
        end
        tx_ready <= stall ? !tx_ready : 1'b1;
    end
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_last = 1'b0;
        tx_ready = 1'b1;
        n = 0;
    end
endmodule : tbrw_reader

// ---- tb/test_typeb_request_wakeup_responder.sv ----
// Purpose: self-checking bench of the Type B responder
// Assumes: reader model drives frames, bench drives registers
// Notes: a fixed wait after each frame also covers the guard time
module test_typeb_request_wakeup_responder
    import tbrw_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys, rst_n, reg_wr, reg_rd, rx_valid, rx_last, tx_valid;
    logic tx_last, tx_ready, stall;
    logic [7:0] reg_addr, rx_data, tx_data;
    logic [31:0] reg_wdata, reg_rdata;
    logic [1:0] tag_state;
    logic [31:0] pupi = 32'h1234_5678;
    logic [3:0] fwi = 4'h5;
    int fail_count = 0;
    int check_count = 0;
    tbrw_responder tbrw_responder_i (.clk_sys(clk_sys), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_last(rx_last), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
        .tag_state(tag_state));
    tbrw_reader tbrw_reader_i (.clk_sys(clk_sys), .stall(stall),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
        .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data));
    task automatic chk(input logic [31:0] got, exp, input string m);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e, "register read");
    endtask : rd
    // one request, then the whole answer or silence is checked
    task automatic fr(input logic [7:0] cmd, afi, prm, input bit bad,
                      input bit ans, input logic [7:0] p1);
        logic [7:0] e [0:11];
        logic [15:0] c;
        e = '{ANS_CODE, pupi[31:24], pupi[23:16], pupi[15:8], pupi[7:0],
              8'h00, 8'h00, 8'h00, 8'h00, p1, 8'h81, {fwi, 4'h0}};
        c = CRC_INIT;
        tbrw_reader_i.send(cmd, afi, prm, bad);
        repeat (60) @(posedge clk_sys);
        chk(tbrw_reader_i.n, ans ? 14 : 0, "answer length");
        for (int i = 0; i < 14 && ans; i++) begin
            c = tbrw_reader_i.crc_step(c, tbrw_reader_i.ans[i]);
            if (i < 12) begin
                chk(tbrw_reader_i.ans[i], e[i], "answer byte");
            end
        end
        if (ans) chk(c, CRC_RESIDUE, "answer crc");
        $display("test frame %h %h %h done", cmd, afi, prm);
    endtask : fr
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // watchdog: the tests need about 950 cycles
    initial begin
        repeat (5000) @(posedge clk_sys);
        fail_count++;
        print_verdict();
    end
    initial begin
        {rst_n, reg_wr, reg_rd, stall, reg_addr, reg_wdata} = '0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(ADDR_CFG, 32'h0);
        rd(ADDR_PUPI, PUPI_RESET);
        rd(8'h10, 32'h0);
        wr(ADDR_PUPI, pupi);
        wr(ADDR_CFG, {18'h0, 1'b1, 1'b0, fwi, 8'h3A});
        fr(8'h05, 8'h00, 8'h00, 0, 1, 8'hB3);
        fr(8'h05, 8'h30, 8'hE7, 0, 1, 8'hB3);
        fr(8'h05, 8'h40, 8'h00, 0, 0, 8'hB3);
        fr(8'h05, 8'h0A, 8'h05, 0, 1, 8'hB3);
        fr(8'h05, 8'h0B, 8'h00, 0, 0, 8'hB3);
        fr(8'h05, 8'h3A, 8'h06, 0, 1, 8'hB3);
        fr(8'h05, 8'h3B, 8'h00, 0, 0, 8'hB3);
        fr(8'h06, 8'h00, 8'h00, 0, 0, 8'hB3);
        fr(8'h05, 8'h00, 8'h00, 1, 0, 8'hB3);
        rd(ADDR_STAT, 32'h0004_0104);
        stall <= 1'b1;
        wr(ADDR_CFG, {18'h0, 1'b1, 1'b1, fwi, 8'h3A});
        fr(8'h05, 8'h00, 8'h00, 0, 1, 8'h80);
        stall <= 1'b0;
        wr(ADDR_CFG, {18'h0, 1'b0, 1'b1, fwi, 8'h3A});
        fr(8'h05, 8'h0A, 8'h00, 0, 1, 8'h80);
        wr(ADDR_STATE, {30'h0, TBRW_HALT});
        fr(8'h05, 8'h00, 8'h00, 0, 0, 8'h80);
        chk({30'h0, tag_state}, {30'h0, TBRW_HALT}, "tag state");
        fr(8'h05, 8'h00, 8'h08, 0, 1, 8'h80);
        chk({30'h0, tag_state}, {30'h0, TBRW_READY}, "tag state");
        rd(ADDR_STATE, {30'h0, TBRW_READY});
        wr(ADDR_STATE, {30'h0, TBRW_IDLE});
        wr(ADDR_CFG, {18'h0, 1'b0, 1'b0, fwi, 8'h3A});
        fr(8'h05, 8'h00, 8'h08, 0, 1, 8'h80);
        print_verdict();
    end
endmodule : test_typeb_request_wakeup_responder
